// file: logic/spp_cfg.svh
`ifndef SPP_CFG_SVH
`define SPP_CFG_SVH

// register byte offsets on the bus
`define SPP_OFF_DATA    8'h00
`define SPP_OFF_CTRL    8'h04
`define SPP_OFF_ANA     8'h08
`define SPP_OFF_IST     8'h0C
`define SPP_OFF_IMSK    8'h10

// control/status register field positions
`define SPP_CTRL_IBF    7
`define SPP_CTRL_OBF    6
`define SPP_CTRL_INPUT_OVERRUN   5
`define SPP_CTRL_MODE   4
`define SPP_CTRL_DIRHI  2

// event bit in status and mask registers
`define SPP_EV_BIT      0

// reset values, and the direction value that makes all three pins inputs
`define SPP_DIR_RST     3'h7
`define SPP_ANA_RST     4'h0
`define SPP_DIR_INPUTS  3'h7

// digital range of the analog pin select field
`define SPP_ANA_MIN     4'hA
`define SPP_ANA_MAX     4'hF

// bus responses
`define SPP_RESP_OKAY   2'h0
`define SPP_RESP_SLVERR 2'h2

// synchroniser: {chipSelectN, writeStrobeN, readStrobeN, data[7:0]}
`define SPP_SYNC_W      11
`define SPP_SYNC_RST    11'h700

`endif

// file: logic/spp_pkg.sv
`include "spp_cfg.svh"

package spp_pkg;

    typedef struct packed {
        logic [`SPP_SYNC_W-1:0] s1;
        logic [`SPP_SYNC_W-1:0] s2;
        logic [`SPP_SYNC_W-1:0] s3;
        logic [`SPP_SYNC_W-1:0] value;
    } spp_sync_state_t;

    typedef struct packed {
        logic wrOn;
        logic rdOn;
        logic writeEnd;
        logic readStart;
        logic readEnd;
    } spp_track_state_t;

    typedef struct packed {
        logic       awHeld;
        logic       wHeld;
        logic [7:0] awAddr;
        logic [7:0] wData;
        logic       wLane;
        logic       awready;
        logic       wready;
        logic       bvalid;
        logic [1:0] bresp;
        logic       arready;
        logic       rvalid;
        logic [1:0] rresp;
        logic [7:0] rdLow;
        logic       mode;
        logic [2:0] dirs;
        logic [3:0] anaSel;
        logic       inFull;
        logic       outPending;
        logic       overrun;
        logic [7:0] inByte;
        logic [7:0] outLatch;
        logic       evFlag;
        logic       evMask;
        logic       irq;
        logic       dataOe;
    } spp_top_state_t;

endpackage

// file: logic/spp_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
`include "spp_cfg.svh"

module spp_pin_sync (
    input  wire logic                   mclk,
    input  wire logic                   rst,
    input  wire logic [`SPP_SYNC_W-1:0] rawIn,
    output logic      [`SPP_SYNC_W-1:0] cleanOut
);
    import spp_pkg::*;

    spp_sync_state_t st;
    spp_sync_state_t next_st;

    // s1 feeds only s2; a bit is accepted once s2 and s3 agree
    always_comb begin
        next_st = st;
        next_st.s1 = rawIn;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < `SPP_SYNC_W; i++) begin
            if (st.s2[i] == st.s3[i]) begin
                next_st.value[i] = st.s2[i];
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st <= {4{`SPP_SYNC_RST}};
        end else begin
            st <= next_st;
        end
    end

    assign cleanOut = st.value;

    a_sync_agree: assert property (@(posedge mclk) disable iff (rst)
        (st.value != $past(st.value)) |-> ($past(st.s2) == $past(st.s3)))
        else $error("accepted pin value changed before two stages agreed");

endmodule // spp_pin_sync

`default_nettype wire

// file: logic/spp_cycle_track.sv
`timescale 1ns/1ps
`default_nettype none

module spp_cycle_track (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic enable,
    input  wire logic chipSelectN,
    input  wire logic readStrobeN,
    input  wire logic writeStrobeN,
    output logic      writeEnd,
    output logic      readStart,
    output logic      readEnd,
    output logic      readActive
);
    import spp_pkg::*;

    spp_track_state_t st;
    spp_track_state_t next_st;

    always_comb begin
        next_st = st;
        next_st.wrOn = enable & ~chipSelectN & ~writeStrobeN;
        next_st.rdOn = enable & ~chipSelectN & ~readStrobeN;
        // leaving slave mode mid-cycle drops the cycle without an event
        next_st.writeEnd = st.wrOn & enable & (chipSelectN | writeStrobeN);
        next_st.readStart = ~st.rdOn & next_st.rdOn;
        next_st.readEnd = st.rdOn & enable & (chipSelectN | readStrobeN);
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign writeEnd   = st.writeEnd;
    assign readStart  = st.readStart;
    assign readEnd    = st.readEnd;
    assign readActive = st.rdOn;

    sequence wrOpen;
        st.wrOn && enable;
    endsequence

    sequence wrReleased;
        chipSelectN || writeStrobeN;
    endsequence

    a_write_end_detect: assert property (@(posedge mclk) disable iff (rst)
        (wrOpen ##0 wrReleased) |=> writeEnd)
        else $error("write cycle end not flagged");

    a_write_end_cause: assert property (@(posedge mclk) disable iff (rst)
        writeEnd |-> ($past(st.wrOn) && !st.wrOn))
        else $error("write end flagged without an open write cycle");

endmodule // spp_cycle_track

`default_nettype wire

// file: logic/spp_parallel_slave_port.sv
// Overview of operation
// - slave mode runs when select bit set, multi-output PWM is off, all three direction bits set and analog select in 0xA..0xF
// - external processor reads and writes the 8-bit latch asynchronously
// - control pins 0,1,2 are active-low read, write and chip select
// - write starts with select and write low, ends when either high
// - at write end, capture byte, set event flag and input-full
// - select and read low: drive latch onto pins, clear output-pending
// - software write during a read drives at once, pending stays clear
// - select or read high after read: release pins, set event flag
// - write end with unread input byte sets overrun until software clears
// - software data write outside a read sets pending until read out
`timescale 1ns/1ps
`default_nettype none
`include "spp_cfg.svh"

module spp_parallel_slave_port (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [7:0]  dataIn,
    output logic [7:0]       dataOut,
    output logic             dataOe,
    input  wire logic        readStrobeN,
    input  wire logic        writeStrobeN,
    input  wire logic        chipSelectN,
    input  wire logic        pwmMultiOutput,
    output logic             irq
);
    import spp_pkg::*;

    spp_top_state_t st;
    spp_top_state_t next_st;

    logic [`SPP_SYNC_W-1:0] syncVal;
    logic [7:0]             syncData;
    logic                   active;
    logic                   trkWriteEnd;
    logic                   trkReadStart;
    logic                   trkReadEnd;
    logic                   trkReadActive;
    logic                   swDataWr;
    logic                   swDataRd;
    logic                   swIstRd;

    function automatic logic isMapped(input logic [7:0] addr);
        return (addr == `SPP_OFF_DATA) || (addr == `SPP_OFF_CTRL) ||
               (addr == `SPP_OFF_ANA) || (addr == `SPP_OFF_IST) ||
               (addr == `SPP_OFF_IMSK);
    endfunction

    spp_pin_sync u_sync (
        .mclk     (mclk),
        .rst      (rst),
        .rawIn    ({chipSelectN, writeStrobeN, readStrobeN, dataIn}),
        .cleanOut (syncVal)
    );

    assign syncData = syncVal[7:0];

    // pins only act as strobes once software made them digital inputs
    assign active = st.mode & ~pwmMultiOutput
                  & (st.dirs == `SPP_DIR_INPUTS)
                  & (st.anaSel >= `SPP_ANA_MIN) & (st.anaSel <= `SPP_ANA_MAX);

    spp_cycle_track u_track (
        .mclk         (mclk),
        .rst          (rst),
        .enable       (active),
        .chipSelectN  (syncVal[10]),
        .writeStrobeN (syncVal[9]),
        .readStrobeN  (syncVal[8]),
        .writeEnd     (trkWriteEnd),
        .readStart    (trkReadStart),
        .readEnd      (trkReadEnd),
        .readActive   (trkReadActive)
    );

    always_comb begin
        next_st = st;
        swDataWr = 1'b0;
        swDataRd = 1'b0;
        swIstRd = 1'b0;

        // write channel: address and data taken in either order
        if (s_axi_awvalid && st.awready) begin
            next_st.awHeld = 1'b1;
            next_st.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st.wready) begin
            next_st.wHeld = 1'b1;
            next_st.wData = s_axi_wdata[7:0];
            next_st.wLane = s_axi_wstrb[0];
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        if (st.awHeld && st.wHeld && !st.bvalid) begin
            next_st.awHeld = 1'b0;
            next_st.wHeld = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = isMapped(st.awAddr) ? `SPP_RESP_OKAY : `SPP_RESP_SLVERR;
            if (st.wLane) begin
                unique case (st.awAddr)
                    `SPP_OFF_DATA: begin
                        next_st.outLatch = st.wData;
                        swDataWr = 1'b1;
                    end
                    `SPP_OFF_CTRL: begin
                        next_st.mode = st.wData[`SPP_CTRL_MODE];
                        next_st.overrun = st.wData[`SPP_CTRL_INPUT_OVERRUN];
                        next_st.dirs = st.wData[`SPP_CTRL_DIRHI:0];
                    end
                    `SPP_OFF_ANA: begin
                        next_st.anaSel = st.wData[3:0];
                    end
                    `SPP_OFF_IMSK: begin
                        next_st.evMask = st.wData[`SPP_EV_BIT];
                    end
                    default: begin
                    end
                endcase
            end
        end

        // read channel; data and event status reads have side effects
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st.arready) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = isMapped(s_axi_araddr) ? `SPP_RESP_OKAY : `SPP_RESP_SLVERR;
            unique case (s_axi_araddr)
                `SPP_OFF_DATA: begin
                    next_st.rdLow = st.inByte;
                    swDataRd = 1'b1;
                end
                `SPP_OFF_CTRL: begin
                    next_st.rdLow = {st.inFull, st.outPending, st.overrun, st.mode,
                                     1'b0, st.dirs};
                end
                `SPP_OFF_ANA: begin
                    next_st.rdLow = {4'h0, st.anaSel};
                end
                `SPP_OFF_IST: begin
                    next_st.rdLow = {7'h00, st.evFlag};
                    swIstRd = 1'b1;
                end
                `SPP_OFF_IMSK: begin
                    next_st.rdLow = {7'h00, st.evMask};
                end
                default: begin
                    next_st.rdLow = 8'h00;
                end
            endcase
        end

        // software clears first so that a hardware set in the same cycle wins
        if (swIstRd) begin
            next_st.evFlag = 1'b0;
        end
        if (swDataRd) begin
            next_st.inFull = 1'b0;
        end
        if (swDataWr && !trkReadActive) begin
            next_st.outPending = 1'b1;
        end
        if (trkReadStart) begin
            next_st.outPending = 1'b0;
        end
        if (trkWriteEnd) begin
            // data has been stable since the strobe fell, so the filtered copy is settled
            next_st.inByte = syncData;
            if (st.inFull && !swDataRd) begin
                next_st.overrun = 1'b1;
            end
            next_st.inFull = 1'b1;
            next_st.evFlag = 1'b1;
        end
        if (trkReadEnd) begin
            next_st.evFlag = 1'b1;
        end

        // pins driven only for the length of an external read
        next_st.dataOe = active & trkReadActive;
        next_st.irq = next_st.evFlag & next_st.evMask;
        next_st.awready = ~next_st.awHeld & ~next_st.bvalid;
        next_st.wready = ~next_st.wHeld & ~next_st.bvalid;
        next_st.arready = ~next_st.rvalid;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st <= '0;
            st.dirs <= `SPP_DIR_RST;
            st.anaSel <= `SPP_ANA_RST;
        end else begin
            st <= next_st;
        end
    end

    assign s_axi_awready = st.awready;
    assign s_axi_wready  = st.wready;
    assign s_axi_bvalid  = st.bvalid;
    assign s_axi_bresp   = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid  = st.rvalid;
    assign s_axi_rresp   = st.rresp;
    assign s_axi_rdata   = {24'h00_0000, st.rdLow};
    assign dataOut       = st.outLatch;
    assign dataOe        = st.dataOe;
    assign irq           = st.irq;

    sequence readGoing;
        trkReadActive && active;
    endsequence

    sequence wrPair;
        st.awHeld && st.wHeld && !st.bvalid;
    endsequence

    a_pins_follow_read: assert property (@(posedge mclk) disable iff (rst)
        readGoing |=> st.dataOe)
        else $error("data pins not driven during an external read");

    a_release_pins: assert property (@(posedge mclk) disable iff (rst)
        trkReadEnd |=> (!st.dataOe && st.evFlag))
        else $error("pins not released or event missing after read");

    a_pwm_gate: assert property (@(posedge mclk) disable iff (rst)
        (pwmMultiOutput || !st.mode) |=> !st.dataOe)
        else $error("pins driven while slave mode is not in force");

    a_write_end_flags: assert property (@(posedge mclk) disable iff (rst)
        trkWriteEnd |=> (st.inFull && st.evFlag && st.inByte == $past(syncData)))
        else $error("write end did not capture byte and set flags");

    a_overrun_set: assert property (@(posedge mclk) disable iff (rst)
        (trkWriteEnd && st.inFull && !swDataRd) |=> st.overrun)
        else $error("overrun not flagged on unread input");

    a_pending_on_write: assert property (@(posedge mclk) disable iff (rst)
        (swDataWr && !trkReadActive) |=> st.outPending)
        else $error("output pending not set by software write");

    a_pending_in_read: assert property (@(posedge mclk) disable iff (rst)
        (swDataWr && trkReadActive && !st.outPending) |=>
        (!st.outPending && dataOut == $past(st.wData)))
        else $error("write during read set pending or missed pins");

    a_read_clears_pend: assert property (@(posedge mclk) disable iff (rst)
        trkReadStart |=> !st.outPending)
        else $error("output pending not cleared at read start");

    a_bus_write_resp: assert property (@(posedge mclk) disable iff (rst)
        wrPair |=> (st.bvalid && !st.awready && !st.wready))
        else $error("write response not raised after address and data");

    a_event_read_clr: assert property (@(posedge mclk) disable iff (rst)
        (swIstRd && !trkWriteEnd && !trkReadEnd) |=> (!st.evFlag && !irq))
        else $error("status read did not clear event and interrupt");

    a_read_accept: assert property (@(posedge mclk) disable iff (rst)
        (s_axi_arvalid && st.arready) |=> (st.rvalid && !st.arready))
        else $error("read address accepted without a read response");

    a_unmapped_read: assert property (@(posedge mclk) disable iff (rst)
        (s_axi_arvalid && st.arready && !isMapped(s_axi_araddr)) |=>
        (st.rresp == `SPP_RESP_SLVERR && st.rdLow == 8'h00))
        else $error("unmapped read not answered with error and zero data");

    a_data_read_clr: assert property (@(posedge mclk) disable iff (rst)
        (swDataRd && !trkWriteEnd) |=> !st.inFull)
        else $error("data read did not clear input full");

    // overrun may only fall through a software write of the control register
    a_overrun_hold: assert property (@(posedge mclk) disable iff (rst)
        (st.overrun && !(st.awHeld && st.wHeld && !st.bvalid && st.wLane &&
                         st.awAddr == `SPP_OFF_CTRL)) |=> st.overrun)
        else $error("overrun cleared without a control write");

    a_idle_no_events: assert property (@(posedge mclk) disable iff (rst)
        !active |=> (!trkWriteEnd && !trkReadEnd))
        else $error("pin cycle event while slave mode is off");

endmodule // spp_parallel_slave_port

`default_nettype wire

// file: tb/spp_ext_cpu.sv
`timescale 1ns/1ps
`default_nettype none

module spp_ext_cpu (
    input  wire logic       mclk,
    input  wire logic [7:0] dataOut,
    input  wire logic       dataOe,
    output logic      [7:0] dataIn,
    output logic            chipSelectN,
    output logic            readStrobeN,
    output logic            writeStrobeN
);
    // each level outlasts the device's four-flop synchroniser
    localparam int HOLD = 8;

    initial begin
        dataIn = 8'hA5;
        chipSelectN = 1'b1;
        readStrobeN = 1'b1;
        writeStrobeN = 1'b1;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic write_byte(input logic [7:0] b);
        @(posedge mclk);
        dataIn <= b;
        chipSelectN <= 1'b0;
        writeStrobeN <= 1'b0;
        wait_clk(HOLD);
        chipSelectN <= 1'b1;
        writeStrobeN <= 1'b1;
        wait_clk(2);
        // no pull on the bus: a released line shows the opposite level
        dataIn <= ~b;
        wait_clk(HOLD);
    endtask

    // the bus is never driven here while the read strobe is low
    task automatic read_open;
        @(posedge mclk);
        chipSelectN <= 1'b0;
        readStrobeN <= 1'b0;
        wait_clk(HOLD);
    endtask

    task automatic read_close(output logic [7:0] b, output logic oe);
        @(negedge mclk);
        b = dataOut;
        oe = dataOe;
        @(posedge mclk);
        chipSelectN <= 1'b1;
        readStrobeN <= 1'b1;
        wait_clk(HOLD);
    endtask
endmodule // spp_ext_cpu

`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "spp_cfg.svh"

module tb_top;
    localparam int LIMIT = 20000;
    localparam logic [3:0] ANA_V [4] = '{4'h9, 4'hA, 4'hF, 4'hA};
    localparam logic PWM_V [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
    localparam logic [31:0] CTL_V [4] = '{32'h0000_0017, 32'h0000_0097,
                                          32'h0000_0097, 32'h0000_0017};
    // an ignored pin write leaves the last captured byte in place
    localparam logic [7:0] DAT_V [4] = '{8'h22, 8'h41, 8'h42, 8'h42};
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready = 1'b0;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready = 1'b0;
    logic [7:0]  dataIn;
    logic [7:0]  dataOut;
    logic        dataOe;
    logic        readStrobeN;
    logic        writeStrobeN;
    logic        chipSelectN;
    logic        pwmMultiOutput = 1'b0;
    logic        irq;
    int          errTotal = 0;
    int          nTests = 0;
    int          cycles = 0;

    always #50 mclk = ~mclk;

    spp_parallel_slave_port spp_parallel_slave_port_i (
        .mclk(mclk), .rst(rst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .dataIn(dataIn), .dataOut(dataOut),
        .dataOe(dataOe), .readStrobeN(readStrobeN), .writeStrobeN(writeStrobeN),
        .chipSelectN(chipSelectN), .pwmMultiOutput(pwmMultiOutput), .irq(irq)
    );

    spp_ext_cpu spp_ext_cpu_i (
        .mclk(mclk), .dataOut(dataOut), .dataOe(dataOe), .dataIn(dataIn),
        .chipSelectN(chipSelectN), .readStrobeN(readStrobeN),
        .writeStrobeN(writeStrobeN)
    );

    task automatic final_report;
        $display("comparisons %0d, mismatches %0d", nTests, errTotal);
        if (errTotal == 0 && nTests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == LIMIT) begin
            errTotal++;
            $display("timeout after %0d cycles", cycles);
            final_report();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nTests++;
        if (got !== exp) begin
            errTotal++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // ready and valid come from flops, so the negedge shows what the next edge sees
    task automatic axi_write(input logic [7:0] a, input logic [7:0] v, output logic [1:0] r);
        bit awOk;
        bit wOk;
        bit bOk;
        awOk = 1'b0;
        wOk = 1'b0;
        bOk = 1'b0;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {24'h00_0000, v};
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(awOk && wOk)) begin
            @(negedge mclk);
            awOk = awOk | (s_axi_awvalid & s_axi_awready);
            wOk = wOk | (s_axi_wvalid & s_axi_wready);
            @(posedge mclk);
            if (awOk) s_axi_awvalid <= 1'b0;
            if (wOk) s_axi_wvalid <= 1'b0;
        end
        while (!bOk) begin
            @(negedge mclk);
            bOk = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge mclk);
        end
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        bit arOk;
        bit rOk;
        arOk = 1'b0;
        rOk = 1'b0;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!arOk) begin
            @(negedge mclk);
            arOk = s_axi_arready;
            @(posedge mclk);
        end
        s_axi_arvalid <= 1'b0;
        while (!rOk) begin
            @(negedge mclk);
            rOk = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge mclk);
        end
        s_axi_rready <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        logic [1:0] r;
        axi_write(a, v, r);
        chk({30'h0, r}, {30'h0, `SPP_RESP_OKAY});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(a, d, r);
        chk(d, exp);
        chk({30'h0, r}, {30'h0, `SPP_RESP_OKAY});
    endtask

    task automatic pin(input logic got, input logic exp);
        @(negedge mclk);
        chk({31'h0, got}, {31'h0, exp});
    endtask

    task automatic t_reset;
        logic [31:0] d;
        logic [1:0] r;
        rd(`SPP_OFF_CTRL, 32'h0000_0007);
        rd(`SPP_OFF_ANA, 32'h0000_0000);
        rd(`SPP_OFF_IST, 32'h0000_0000);
        rd(`SPP_OFF_IMSK, 32'h0000_0000);
        axi_read(8'h14, d, r);
        chk({30'h0, r}, {30'h0, `SPP_RESP_SLVERR});
        chk(d, 32'h0000_0000);
        axi_write(8'h14, 8'hFF, r);
        chk({30'h0, r}, {30'h0, `SPP_RESP_SLVERR});
        s_axi_wstrb <= 4'h0;
        wr(`SPP_OFF_ANA, 8'h0F);
        s_axi_wstrb <= 4'hF;
        rd(`SPP_OFF_ANA, 32'h0000_0000);
        $display("test reset values finished");
    endtask

    task automatic t_setup;
        wr(`SPP_OFF_CTRL, 8'h17);
        wr(`SPP_OFF_ANA, 8'h0A);
        rd(`SPP_OFF_CTRL, 32'h0000_0017);
        rd(`SPP_OFF_ANA, 32'h0000_000A);
        $display("test setup finished");
    endtask

    task automatic t_ext_write;
        spp_ext_cpu_i.write_byte(8'h5A);
        pin(irq, 1'b0);
        rd(`SPP_OFF_CTRL, 32'h0000_0097);
        wr(`SPP_OFF_IMSK, 8'h01);
        pin(irq, 1'b1);
        rd(`SPP_OFF_IST, 32'h0000_0001);
        pin(irq, 1'b0);
        rd(`SPP_OFF_DATA, 32'h0000_005A);
        rd(`SPP_OFF_CTRL, 32'h0000_0017);
        $display("test external write finished");
    endtask

    task automatic t_overrun;
        spp_ext_cpu_i.write_byte(8'h11);
        spp_ext_cpu_i.write_byte(8'h22);
        rd(`SPP_OFF_CTRL, 32'h0000_00B7);
        rd(`SPP_OFF_DATA, 32'h0000_0022);
        rd(`SPP_OFF_CTRL, 32'h0000_0037);
        wr(`SPP_OFF_CTRL, 8'h17);
        rd(`SPP_OFF_CTRL, 32'h0000_0017);
        rd(`SPP_OFF_IST, 32'h0000_0001);
        $display("test overrun finished");
    endtask

    task automatic t_ext_read;
        logic [7:0] b;
        logic oe;
        wr(`SPP_OFF_DATA, 8'hC3);
        rd(`SPP_OFF_CTRL, 32'h0000_0057);
        spp_ext_cpu_i.read_open();
        pin(dataOe, 1'b1);
        chk({24'h00_0000, dataOut}, 32'h0000_00C3);
        rd(`SPP_OFF_CTRL, 32'h0000_0017);
        wr(`SPP_OFF_DATA, 8'h3C);
        pin(irq, 1'b0);
        chk({24'h00_0000, dataOut}, 32'h0000_003C);
        rd(`SPP_OFF_CTRL, 32'h0000_0017);
        spp_ext_cpu_i.read_close(b, oe);
        chk({23'h00_0000, oe, b}, 32'h0000_013C);
        pin(dataOe, 1'b0);
        pin(irq, 1'b1);
        rd(`SPP_OFF_IST, 32'h0000_0001);
        $display("test external read finished");
    endtask

    task automatic t_gating;
        for (int i = 0; i < 4; i++) begin
            pwmMultiOutput <= PWM_V[i];
            wr(`SPP_OFF_ANA, {4'h0, ANA_V[i]});
            spp_ext_cpu_i.write_byte(8'h40 + 8'(i));
            rd(`SPP_OFF_CTRL, CTL_V[i]);
            rd(`SPP_OFF_IST, {31'h0, CTL_V[i][`SPP_CTRL_IBF]});
            wr(`SPP_OFF_CTRL, 8'h17);
            rd(`SPP_OFF_DATA, {24'h00_0000, DAT_V[i]});
        end
        $display("test mode gating finished");
    endtask

    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        t_reset();
        t_setup();
        t_ext_write();
        t_overrun();
        t_ext_read();
        t_gating();
        final_report();
    end
endmodule // tb_top

`default_nettype wire
